//--- shared/pps_regs.svh
`ifndef PPS_REGS_SVH
`define PPS_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define PPS_OFF_CTRL 8'h00
`define PPS_OFF_START_MIN 8'h04
`define PPS_OFF_START_MAX 8'h08
`define PPS_OFF_UNDER 8'h0C
`define PPS_OFF_OVER 8'h10
`define PPS_OFF_LIMIT_ONE 8'h14
`define PPS_OFF_SETTLE 8'h18
`define PPS_OFF_INPUT_BLANK 8'h1C
`define PPS_OFF_ONE_BLANK 8'h20
`define PPS_OFF_TWO_BLANK 8'h24
`define PPS_OFF_SS_LIMIT 8'h28
`define PPS_OFF_CCM_BLANK 8'h2C
`define PPS_OFF_STATUS 8'h30
`define PPS_OFF_MASK 8'h34
`define PPS_OFF_STATE 8'h38
`define PPS_OFF_PERIOD 8'h3C

// ==========================================================
// Field positions
`define PPS_CTRL_INPUT_LATCH 0
`define PPS_CTRL_TWO_LATCH 1
`define PPS_EV_UNDER 0
`define PPS_EV_OVER 1
`define PPS_EV_ONE 2
`define PPS_EV_TWO 3
`define PPS_EV_SS 4
`define PPS_EV_CCM 5
`define PPS_EV_COUNT 6

// ==========================================================
// Reset values (Vrms, mV, V)
`define PPS_RST_CTRL 2'h2
`define PPS_RST_START_MIN 12'h058
`define PPS_RST_START_MAX 12'h134
`define PPS_RST_UNDER 12'h04C
`define PPS_RST_OVER 12'h140
`define PPS_RST_LIMIT_ONE 12'h2EE
`define PPS_LIMIT_TWO_MV 12'h640
`define PPS_RST_SETTLE 12'h1C0

// ==========================================================
// Timing
`define PPS_CLK_MHZ 250
`define PPS_INPUT_BLANK_MS 100
`define PPS_ONE_BLANK_NS 200
`define PPS_TWO_BLANK_NS 600
`define PPS_SS_LIMIT_MS 400
`define PPS_CCM_BLANK_MS 12
`define PPS_NS_CYCLES(ns) (((ns) * `PPS_CLK_MHZ + 999) / 1000)
`define PPS_MS_CYCLES(ms) ((ms) * `PPS_CLK_MHZ * 1000)

`endif

//--- shared/pps_pkg.sv
package pps_pkg;
  typedef enum logic [2:0] {
    PPS_STOPPED = 3'h0,
    PPS_CHECKS = 3'h1,
    PPS_SOFTSTART = 3'h2,
    PPS_STEADY = 3'h3,
    PPS_RESTART = 3'h4,
    PPS_LATCH = 3'h5
  } pps_state_t;
endpackage

//--- logic/pps_blank_timer.sv
`timescale 1ns/10ps
module pps_blank_timer #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // Condition and limit
  input wire logic cond_in,
  input wire logic [WIDTH-1:0] limit_in,
  // Result
  output logic fire_out
);
  logic [WIDTH-1:0] count_reg;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("WIDTH must be at least one");
    end
  endgenerate

  // Any gap in the condition starts the wait over
  // Magnitude compare, so a limit lowered mid-count still fires
  always_ff @(posedge clock_in) begin
    if (reset_in || !cond_in) begin
      count_reg <= '0;
    end else if (count_reg < limit_in) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      fire_out <= 1'b0;
    end else begin
      fire_out <= cond_in && (count_reg >= limit_in);
    end
  end
endmodule

//--- logic/pps_supervisor.sv
`timescale 1ns/10ps
`include "pps_regs.svh"

module pps_supervisor #(
  parameter int INPUT_BLANK_CYCLES = `PPS_MS_CYCLES(`PPS_INPUT_BLANK_MS),
  parameter int SS_LIMIT_CYCLES = `PPS_MS_CYCLES(`PPS_SS_LIMIT_MS),
  parameter int CCM_BLANK_CYCLES = `PPS_MS_CYCLES(`PPS_CCM_BLANK_MS),
  parameter int PERIOD_TIMEOUT_CYCLES = 5000,
  parameter int RESTART_CYCLES = 250000,
  parameter int SENSE_WIDTH = 12
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  // Sense channels
  input wire logic supply_on_in,
  input wire logic [SENSE_WIDTH-1:0] line_rms_in,
  input wire logic [SENSE_WIDTH-1:0] boost_cs_mv_in,
  input wire logic [SENSE_WIDTH-1:0] bus_volts_in,
  input wire logic zero_crossing_indication_in,
  input wire logic boost_cycle_start_in,
  // Gate and mode requests
  output logic boost_gate_enable_out,
  output logic flyback_gate_enable_out,
  output logic boost_cycle_off_out,
  output logic auto_restart_out,
  output logic latch_out,
  output logic irq_out
);

  // ========================================================
  // Elaboration checks
  generate
    if (SENSE_WIDTH < 12 || SENSE_WIDTH > 32) begin : g_bad_width
      $error("SENSE_WIDTH must be 12 to 32");
    end
    if (RESTART_CYCLES < 1 || PERIOD_TIMEOUT_CYCLES < 1) begin : g_bad_count
      $error("Restart and period counts must be at least one");
    end
    if (INPUT_BLANK_CYCLES < 1 || SS_LIMIT_CYCLES < 1 || CCM_BLANK_CYCLES < 1) begin : g_bad_blank
      $error("Blanking counts must be at least one");
    end
  endgenerate

  // ========================================================
  // Helpers
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  function automatic logic in_window(input logic [SENSE_WIDTH-1:0] value,
                                     input logic [SENSE_WIDTH-1:0] low,
                                     input logic [SENSE_WIDTH-1:0] high);
    in_window = (value >= low) && (value <= high);
  endfunction

  // ========================================================
  // Registers
  pps_pkg::pps_state_t state_reg;
  pps_pkg::pps_state_t state_next;
  logic [1:0] ctrl_reg;
  logic [SENSE_WIDTH-1:0] start_min_reg;
  logic [SENSE_WIDTH-1:0] start_max_reg;
  logic [SENSE_WIDTH-1:0] under_reg;
  logic [SENSE_WIDTH-1:0] over_reg;
  logic [SENSE_WIDTH-1:0] limit_one_reg;
  logic [SENSE_WIDTH-1:0] settle_reg;
  logic [31:0] input_blank_reg;
  logic [31:0] one_blank_reg;
  logic [31:0] two_blank_reg;
  logic [31:0] ss_limit_reg;
  logic [31:0] ccm_blank_reg;
  logic [31:0] period_reg;
  logic [`PPS_EV_COUNT-1:0] status_reg;
  logic [`PPS_EV_COUNT-1:0] mask_reg;
  logic [31:0] period_count_reg;
  logic waiting_zcd_reg;
  logic ccm_flag_reg;
  logic [31:0] restart_count_reg;

  logic running;
  logic [`PPS_EV_COUNT-1:0] cond;
  logic [`PPS_EV_COUNT-1:0] fire;
  logic [31:0] limit [`PPS_EV_COUNT];
  logic input_fault;
  logic go_latch;
  logic go_restart;

  // ========================================================
  // Register writes
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ctrl_reg <= `PPS_RST_CTRL;
      start_min_reg <= SENSE_WIDTH'(`PPS_RST_START_MIN);
      start_max_reg <= SENSE_WIDTH'(`PPS_RST_START_MAX);
      under_reg <= SENSE_WIDTH'(`PPS_RST_UNDER);
      over_reg <= SENSE_WIDTH'(`PPS_RST_OVER);
      limit_one_reg <= SENSE_WIDTH'(`PPS_RST_LIMIT_ONE);
      settle_reg <= SENSE_WIDTH'(`PPS_RST_SETTLE);
      input_blank_reg <= 32'(INPUT_BLANK_CYCLES);
      one_blank_reg <= 32'(`PPS_NS_CYCLES(`PPS_ONE_BLANK_NS));
      two_blank_reg <= 32'(`PPS_NS_CYCLES(`PPS_TWO_BLANK_NS));
      ss_limit_reg <= 32'(SS_LIMIT_CYCLES);
      ccm_blank_reg <= 32'(CCM_BLANK_CYCLES);
      period_reg <= 32'(PERIOD_TIMEOUT_CYCLES);
      mask_reg <= '0;
    end else if (wr_in) begin
      if (hit(addr_in, `PPS_OFF_CTRL)) ctrl_reg <= wr_data_in[1:0];
      if (hit(addr_in, `PPS_OFF_START_MIN)) start_min_reg <= wr_data_in[SENSE_WIDTH-1:0];
      if (hit(addr_in, `PPS_OFF_START_MAX)) start_max_reg <= wr_data_in[SENSE_WIDTH-1:0];
      if (hit(addr_in, `PPS_OFF_UNDER)) under_reg <= wr_data_in[SENSE_WIDTH-1:0];
      if (hit(addr_in, `PPS_OFF_OVER)) over_reg <= wr_data_in[SENSE_WIDTH-1:0];
      if (hit(addr_in, `PPS_OFF_LIMIT_ONE)) limit_one_reg <= wr_data_in[SENSE_WIDTH-1:0];
      if (hit(addr_in, `PPS_OFF_SETTLE)) settle_reg <= wr_data_in[SENSE_WIDTH-1:0];
      if (hit(addr_in, `PPS_OFF_INPUT_BLANK)) input_blank_reg <= wr_data_in;
      if (hit(addr_in, `PPS_OFF_ONE_BLANK)) one_blank_reg <= wr_data_in;
      if (hit(addr_in, `PPS_OFF_TWO_BLANK)) two_blank_reg <= wr_data_in;
      if (hit(addr_in, `PPS_OFF_SS_LIMIT)) ss_limit_reg <= wr_data_in;
      if (hit(addr_in, `PPS_OFF_CCM_BLANK)) ccm_blank_reg <= wr_data_in;
      if (hit(addr_in, `PPS_OFF_PERIOD)) period_reg <= wr_data_in;
      if (hit(addr_in, `PPS_OFF_MASK)) mask_reg <= wr_data_in[`PPS_EV_COUNT-1:0];
    end
  end

  // ========================================================
  // Register reads, data valid only in the cycle after the strobe
  always_ff @(posedge clock_in) begin
    if (reset_in || !rd_in) begin
      rd_data_out <= 32'h00000000;
    end else begin
      case (addr_in)
        `PPS_OFF_CTRL: rd_data_out <= {30'h00000000, ctrl_reg};
        `PPS_OFF_START_MIN: rd_data_out <= 32'(start_min_reg);
        `PPS_OFF_START_MAX: rd_data_out <= 32'(start_max_reg);
        `PPS_OFF_UNDER: rd_data_out <= 32'(under_reg);
        `PPS_OFF_OVER: rd_data_out <= 32'(over_reg);
        `PPS_OFF_LIMIT_ONE: rd_data_out <= 32'(limit_one_reg);
        `PPS_OFF_SETTLE: rd_data_out <= 32'(settle_reg);
        `PPS_OFF_INPUT_BLANK: rd_data_out <= input_blank_reg;
        `PPS_OFF_ONE_BLANK: rd_data_out <= one_blank_reg;
        `PPS_OFF_TWO_BLANK: rd_data_out <= two_blank_reg;
        `PPS_OFF_SS_LIMIT: rd_data_out <= ss_limit_reg;
        `PPS_OFF_CCM_BLANK: rd_data_out <= ccm_blank_reg;
        `PPS_OFF_STATUS: rd_data_out <= 32'(status_reg);
        `PPS_OFF_MASK: rd_data_out <= 32'(mask_reg);
        `PPS_OFF_STATE: rd_data_out <= {29'h00000000, state_reg};
        `PPS_OFF_PERIOD: rd_data_out <= period_reg;
        default: rd_data_out <= 32'h00000000;
      endcase
    end
  end

  // ========================================================
  // Fault conditions, only while the boost stage runs
  assign running = (state_reg == pps_pkg::PPS_SOFTSTART) ||
                   (state_reg == pps_pkg::PPS_STEADY);

  always_comb begin
    cond = '0;
    cond[`PPS_EV_UNDER] = running && (line_rms_in < under_reg);
    cond[`PPS_EV_OVER] = running && (line_rms_in > over_reg);
    cond[`PPS_EV_ONE] = running && (boost_cs_mv_in >= limit_one_reg);
    cond[`PPS_EV_TWO] = running &&
                        (boost_cs_mv_in >= SENSE_WIDTH'(`PPS_LIMIT_TWO_MV));
    cond[`PPS_EV_SS] = (state_reg == pps_pkg::PPS_SOFTSTART);
    // Soft-start excluded so start-up conduction is tolerated
    cond[`PPS_EV_CCM] = (state_reg == pps_pkg::PPS_STEADY) && ccm_flag_reg;
  end

  always_comb begin
    limit[`PPS_EV_UNDER] = input_blank_reg;
    limit[`PPS_EV_OVER] = input_blank_reg;
    limit[`PPS_EV_ONE] = one_blank_reg;
    limit[`PPS_EV_TWO] = two_blank_reg;
    limit[`PPS_EV_SS] = ss_limit_reg;
    limit[`PPS_EV_CCM] = ccm_blank_reg;
  end

  // One blanking timer per fault; each clears when its condition drops
  generate
    for (genvar i = 0; i < `PPS_EV_COUNT; i++) begin : g_blank
      pps_blank_timer #(
        .WIDTH(32)
      ) u_timer (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .cond_in(cond[i]),
        .limit_in(limit[i]),
        .fire_out(fire[i])
      );
    end
  endgenerate

  // ========================================================
  // Switching-period watch for missing zero crossings
  always_ff @(posedge clock_in) begin
    if (reset_in || !running) begin
      period_count_reg <= 32'h00000000;
      waiting_zcd_reg <= 1'b0;
      ccm_flag_reg <= 1'b0;
    end else if (zero_crossing_indication_in) begin
      waiting_zcd_reg <= 1'b0;
      ccm_flag_reg <= 1'b0;
    end else if (boost_cycle_start_in) begin
      period_count_reg <= 32'h00000000;
      waiting_zcd_reg <= 1'b1;
    end else if (waiting_zcd_reg) begin
      if (period_count_reg >= period_reg) begin
        ccm_flag_reg <= 1'b1;
        waiting_zcd_reg <= 1'b0;
      end else begin
        period_count_reg <= period_count_reg + 32'h00000001;
      end
    end
  end

  // Cycle-by-cycle gate off; a new trip beats the releasing crossing
  always_ff @(posedge clock_in) begin
    if (reset_in || !running) begin
      boost_cycle_off_out <= 1'b0;
    end else if (fire[`PPS_EV_ONE]) begin
      boost_cycle_off_out <= 1'b1;
    end else if (zero_crossing_indication_in) begin
      boost_cycle_off_out <= 1'b0;
    end
  end

  // ========================================================
  // Reaction selection
  assign input_fault = fire[`PPS_EV_UNDER] || fire[`PPS_EV_OVER];
  assign go_latch = (input_fault && ctrl_reg[`PPS_CTRL_INPUT_LATCH]) ||
                    (fire[`PPS_EV_TWO] && ctrl_reg[`PPS_CTRL_TWO_LATCH]);
  assign go_restart = (input_fault && !ctrl_reg[`PPS_CTRL_INPUT_LATCH]) ||
                      (fire[`PPS_EV_TWO] && !ctrl_reg[`PPS_CTRL_TWO_LATCH]) ||
                      fire[`PPS_EV_SS] ||
                      fire[`PPS_EV_CCM];

  // ========================================================
  // Supervisor state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pps_pkg::PPS_STOPPED: begin
        if (supply_on_in) begin
          state_next = pps_pkg::PPS_CHECKS;
        end
      end
      pps_pkg::PPS_CHECKS: begin
        if (!supply_on_in) begin
          state_next = pps_pkg::PPS_STOPPED;
        end else if (in_window(line_rms_in, start_min_reg, start_max_reg)) begin
          state_next = pps_pkg::PPS_SOFTSTART;
        end
      end
      pps_pkg::PPS_SOFTSTART, pps_pkg::PPS_STEADY: begin
        if (go_latch) begin
          state_next = pps_pkg::PPS_LATCH;
        end else if (go_restart) begin
          state_next = pps_pkg::PPS_RESTART;
        end else if (!supply_on_in) begin
          state_next = pps_pkg::PPS_STOPPED;
        end else if (state_reg == pps_pkg::PPS_SOFTSTART && bus_volts_in >= settle_reg) begin
          state_next = pps_pkg::PPS_STEADY;
        end
      end
      pps_pkg::PPS_RESTART: begin
        if (restart_count_reg >= 32'(RESTART_CYCLES)) begin
          state_next = pps_pkg::PPS_STOPPED;
        end
      end
      pps_pkg::PPS_LATCH: begin
        state_next = pps_pkg::PPS_LATCH;
      end
      default: begin
        state_next = pps_pkg::PPS_STOPPED;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_reg <= pps_pkg::PPS_STOPPED;
    end else begin
      state_reg <= state_next;
    end
  end

  // Auto-restart hold-off before the checks run again
  always_ff @(posedge clock_in) begin
    if (reset_in || state_reg != pps_pkg::PPS_RESTART) begin
      restart_count_reg <= 32'h00000000;
    end else begin
      restart_count_reg <= restart_count_reg + 32'h00000001;
    end
  end

  // ========================================================
  // Gate and mode outputs follow the next state
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      boost_gate_enable_out <= 1'b0;
      flyback_gate_enable_out <= 1'b0;
      auto_restart_out <= 1'b0;
      latch_out <= 1'b0;
    end else begin
      boost_gate_enable_out <= (state_next == pps_pkg::PPS_SOFTSTART) ||
                               (state_next == pps_pkg::PPS_STEADY);
      flyback_gate_enable_out <= (state_next == pps_pkg::PPS_STEADY);
      auto_restart_out <= (state_next == pps_pkg::PPS_RESTART);
      latch_out <= (state_next == pps_pkg::PPS_LATCH);
    end
  end

  // ========================================================
  // Sticky events, write one to clear, set wins
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg &
                     ~((wr_in && hit(addr_in, `PPS_OFF_STATUS)) ?
                       wr_data_in[`PPS_EV_COUNT-1:0] : {`PPS_EV_COUNT{1'b0}})) |
                    fire;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_reg & mask_reg);
    end
  end

endmodule

//--- dv/pps_front_end.sv
`timescale 1ns/10ps
// ==========================================================
// Boost stage stand-in: bus ramp and switching cycles
module pps_front_end (
  // Clock, reset, gate and scenario controls
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic gate_in,
  input wire logic ccm_in,
  input wire logic hold_bus_in,
  // Sense results
  output logic [11:0] bus_volts_out,
  output logic zcd_out,
  output logic cycle_start_out
);
  logic [3:0] phase_reg;
  // Bus collapses at once when gating stops, the harshest case
  always_ff @(posedge clock_in) begin
    if (reset_in || !gate_in) begin
      phase_reg <= 4'h0;
      bus_volts_out <= 12'h000;
    end else begin
      phase_reg <= (phase_reg == 4'hB) ? 4'h0 : phase_reg + 4'h1;
      if (!hold_bus_in && bus_volts_out < 12'h1CC) begin
        bus_volts_out <= bus_volts_out + 12'h010;
      end
    end
  end
  // New cycle every 12 clocks, whether or not the zero crossing came
  assign cycle_start_out = gate_in && phase_reg == 4'h0;
  assign zcd_out = gate_in && !ccm_in && phase_reg == 4'h4;
endmodule

//--- dv/pps_supervisor_asserts.sv
`timescale 1ns/10ps
// ==========================================================
// Protection timing checks
module pps_supervisor_asserts #(
  parameter int INPUT_BLANK_CYCLES = 20,
  parameter int SS_LIMIT_CYCLES = 40,
  parameter int CCM_BLANK_CYCLES = 20,
  parameter int PERIOD_TIMEOUT_CYCLES = 8,
  parameter int SENSE_WIDTH = 12
) (
  // Clock, reset and inputs
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic rd_in,
  input wire logic supply_on_in,
  input wire logic [SENSE_WIDTH-1:0] line_rms_in,
  input wire logic [SENSE_WIDTH-1:0] boost_cs_mv_in,
  input wire logic zero_crossing_indication_in,
  // Outputs
  input wire logic [31:0] rd_data_out,
  input wire logic boost_gate_enable_out,
  input wire logic flyback_gate_enable_out,
  input wire logic boost_cycle_off_out,
  input wire logic auto_restart_out,
  input wire logic latch_out
);
  // Register defaults; limits assume software leaves them alone
  localparam int ONE_BLANK = 50;
  localparam int TWO_BLANK = 150;
  logic run;
  logic [15:0] one_cnt, two_cnt, ss_cnt, in_cnt, nz_cnt;
  assign run = boost_gate_enable_out;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      one_cnt <= 16'h0;
      two_cnt <= 16'h0;
      ss_cnt <= 16'h0;
      in_cnt <= 16'h0;
      nz_cnt <= 16'h0;
    end else begin
      one_cnt <= (boost_cs_mv_in >= 12'h2EE) ? one_cnt + 16'h1 : 16'h0;
      two_cnt <= (boost_cs_mv_in >= 12'h640 && (run || latch_out)) ? two_cnt + 16'h1 : 16'h0;
      ss_cnt <= (run && !flyback_gate_enable_out) ? ss_cnt + 16'h1 : 16'h0;
      in_cnt <= (run && (line_rms_in < 12'h04C || line_rms_in > 12'h140)) ?
                in_cnt + 16'h1 : 16'h0;
      nz_cnt <= (flyback_gate_enable_out && !zero_crossing_indication_in) ?
                nz_cnt + 16'h1 : 16'h0;
    end
  end
  sequence s_window;
    $past(line_rms_in) >= 12'h058 && $past(line_rms_in) <= 12'h134 && $past(supply_on_in);
  endsequence
  sequence s_restart_hold;
    auto_restart_out[*8];
  endsequence
  property p_rd_idle;
    !$past(rd_in) |-> rd_data_out == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_start_window;
    $rose(run) |-> s_window;
  endproperty
  a_start_window: assert property (p_start_window) else $error("bad start");
  property p_one_blank;
    $rose(boost_cycle_off_out) |-> one_cnt >= ONE_BLANK;
  endproperty
  a_one_blank: assert property (p_one_blank) else $error("early gate off");
  property p_two_latch;
    two_cnt == TWO_BLANK + 4 |-> latch_out;
  endproperty
  a_two_latch: assert property (p_two_latch) else $error("no latch");
  property p_latch_hold;
    latch_out |=> latch_out;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch dropped");
  property p_stop_gates;
    latch_out || auto_restart_out |-> !run && !flyback_gate_enable_out;
  endproperty
  a_stop_gates: assert property (p_stop_gates) else $error("gates on");
  property p_restart_hold;
    $rose(auto_restart_out) |-> s_restart_hold;
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("short restart");
  property p_ss_bound;
    run |-> ss_cnt <= SS_LIMIT_CYCLES + 4;
  endproperty
  a_ss_bound: assert property (p_ss_bound) else $error("soft-start too long");
  property p_in_bound;
    run |-> in_cnt <= INPUT_BLANK_CYCLES + 4;
  endproperty
  a_in_bound: assert property (p_in_bound) else $error("input fault ignored");
  property p_ccm_bound;
    run |-> nz_cnt <= CCM_BLANK_CYCLES + PERIOD_TIMEOUT_CYCLES + 24;
  endproperty
  a_ccm_bound: assert property (p_ccm_bound) else $error("ccm ignored");
endmodule

bind pps_supervisor pps_supervisor_asserts #(
  .INPUT_BLANK_CYCLES(INPUT_BLANK_CYCLES), .SS_LIMIT_CYCLES(SS_LIMIT_CYCLES),
  .CCM_BLANK_CYCLES(CCM_BLANK_CYCLES), .PERIOD_TIMEOUT_CYCLES(PERIOD_TIMEOUT_CYCLES),
  .SENSE_WIDTH(SENSE_WIDTH)
) u_checks (
  .clock_in, .reset_in, .rd_in, .supply_on_in, .line_rms_in, .boost_cs_mv_in,
  .zero_crossing_indication_in, .rd_data_out, .boost_gate_enable_out,
  .flyback_gate_enable_out, .boost_cycle_off_out, .auto_restart_out, .latch_out
);

//--- dv/pps_supervisor_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t: got %0h want %0h", $time, a, b); end end
`define WAITF(c, n) begin int k; k = 0; \
  while (!(c) && k < (n)) begin @(posedge clock_in); #1 k++; end `CHK(c, 1'b1) end
module pps_supervisor_tb;
  localparam int IN_BLANK = 20;
  localparam int SS_LIM = 40;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic supply_on_in = 1'b0;
  logic [11:0] line_rms_in = 12'h0C8;
  logic [11:0] boost_cs_mv_in = 12'h000;
  logic ccm = 1'b0;
  logic hold_bus = 1'b0;
  logic [31:0] rd_data_out, rd_val;
  logic [11:0] bus_volts;
  logic zero_crossing_indication, cyc_start, gate, fly, off, restart, latch, irq;
  int err_count = 0;
  int n_tests = 0;
  logic [11:0] bad_line [2] = '{12'h057, 12'h135};
  logic [7:0] def_addr [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20,
                                8'h24, 8'h34, 8'h38, 8'h40};
  logic [31:0] def_val [12] = '{32'h2, 32'h58, 32'h134, 32'h4C, 32'h140, 32'h2EE, 32'h1C0,
                                32'h32, 32'h96, 32'h0, 32'h0, 32'h0};
  always #2 clock_in = ~clock_in;

  pps_supervisor #(.INPUT_BLANK_CYCLES(IN_BLANK), .SS_LIMIT_CYCLES(SS_LIM),
    .CCM_BLANK_CYCLES(20), .PERIOD_TIMEOUT_CYCLES(8), .RESTART_CYCLES(10)) dut (
    .clock_in, .reset_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out,
    .supply_on_in, .line_rms_in, .boost_cs_mv_in, .bus_volts_in(bus_volts),
    .zero_crossing_indication_in(zero_crossing_indication), .boost_cycle_start_in(cyc_start),
    .boost_gate_enable_out(gate), .flyback_gate_enable_out(fly), .boost_cycle_off_out(off),
    .auto_restart_out(restart), .latch_out(latch), .irq_out(irq));
  pps_front_end stage (.clock_in, .reset_in, .gate_in(gate), .ccm_in(ccm),
    .hold_bus_in(hold_bus), .bus_volts_out(bus_volts), .zcd_out(zero_crossing_indication),
    .cycle_start_out(cyc_start));

  // ==========================================================
  // Register access and run control
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 rd_val = rd_data_out;
  endtask
  // Timing registers shortened so every reaction fits a short run
  task automatic pulse_reset();
    @(posedge clock_in) reset_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    reset_in <= 1'b0;
    wr(8'h1C, 32'h14);
    wr(8'h28, 32'h28);
    wr(8'h2C, 32'h14);
    wr(8'h3C, 32'h8);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    pulse_reset();
    wr(8'h38, 32'h5);
    foreach (def_addr[i]) begin
      rd(def_addr[i]);
      `CHK(rd_val, def_val[i])
    end
    #1 `CHK(gate, 1'b0)
    done("defaults");
    @(posedge clock_in) supply_on_in <= 1'b1;
    foreach (bad_line[i]) begin
      @(posedge clock_in) line_rms_in <= bad_line[i];
      repeat (20) @(posedge clock_in);
      #1 `CHK(gate, 1'b0)
    end
    rd(8'h38);
    `CHK(rd_val, 32'h1)
    @(posedge clock_in) line_rms_in <= 12'h058;
    `WAITF(gate, 10)
    `WAITF(fly, SS_LIM)
    `CHK(bus_volts >= 12'h1C0, 1'b1)
    done("start window");
    // Two short bursts must not add up
    repeat (2) begin
      @(posedge clock_in) boost_cs_mv_in <= 12'h2EE;
      repeat (30) @(posedge clock_in);
      boost_cs_mv_in <= 12'h000;
      repeat (2) @(posedge clock_in);
    end
    #1 `CHK(off, 1'b0)
    @(posedge clock_in) boost_cs_mv_in <= 12'h2EE;
    `WAITF(off, 60)
    @(posedge clock_in) boost_cs_mv_in <= 12'h000;
    `WAITF(!off, 20)
    `CHK(({latch, restart, fly}), 3'b001)
    rd(8'h30);
    `CHK(rd_val[2], 1'b1)
    `CHK(irq, 1'b0)
    wr(8'h34, 32'h4);
    repeat (2) @(posedge clock_in);
    #1 `CHK(irq, 1'b1)
    wr(8'h30, 32'h4);
    repeat (2) @(posedge clock_in);
    #1 `CHK(irq, 1'b0)
    wr(8'h34, 32'h0);
    done("limit one");
    @(posedge clock_in) line_rms_in <= 12'h04B;
    `WAITF(restart, IN_BLANK + 6)
    rd(8'h30);
    `CHK(rd_val[0], 1'b1)
    @(posedge clock_in) line_rms_in <= 12'h0C8;
    `WAITF(fly, 100)
    wr(8'h00, 32'h3);
    @(posedge clock_in) line_rms_in <= 12'h141;
    `WAITF(latch, IN_BLANK + 6)
    @(posedge clock_in) line_rms_in <= 12'h0C8;
    pulse_reset();
    `WAITF(fly, 100)
    done("input faults");
    @(posedge clock_in) ccm <= 1'b1;
    `WAITF(restart, 60)
    rd(8'h30);
    `CHK(rd_val[5], 1'b1)
    `WAITF(fly, 100)
    `WAITF(restart, 60)
    @(posedge clock_in) ccm <= 1'b0;
    hold_bus <= 1'b1;
    `WAITF(gate, 60)
    `WAITF(restart, SS_LIM + 10)
    rd(8'h30);
    `CHK(rd_val[4], 1'b1)
    @(posedge clock_in) hold_bus <= 1'b0;
    `WAITF(fly, 100)
    done("ccm and soft-start");
    // Limit two with the auto-restart reaction selected, then with the latch reaction
    wr(8'h00, 32'h0);
    @(posedge clock_in) boost_cs_mv_in <= 12'h640;
    `WAITF(restart, 160)
    @(posedge clock_in) boost_cs_mv_in <= 12'h000;
    `CHK(latch, 1'b0)
    rd(8'h30);
    `CHK(rd_val[3], 1'b1)
    wr(8'h00, 32'h2);
    `WAITF(fly, 100)
    @(posedge clock_in) boost_cs_mv_in <= 12'h640;
    `WAITF(latch, 160)
    `CHK(({gate, fly}), 2'b00)
    @(posedge clock_in) boost_cs_mv_in <= 12'h000;
    repeat (30) @(posedge clock_in);
    #1 `CHK(latch, 1'b1)
    pulse_reset();
    #1 `CHK(latch, 1'b0)
    done("limit two");
    results();
  end

  initial begin
    #20000;
    err_count++;
    results();
  end
endmodule
